//--- core/aoc_defines.svh
// Operation
// R1: channel range type is disabled-voltage, disabled-current or active; default disabled-current.
// R2: active ranges are +-10 V, 0..10 V, 4..20 mA, 0..20 mA; default +-10 V.
// R3: host must give HART channels active type and the 4..20 mA range.
// R4: commanded value is int16 or float32 per channel; float is the default.
// R5: disabled-current channel forces zero output current.
// R6: disabled-voltage channel forces zero output voltage.
// R7: hold selected keeps last value on disable or fault, else go to default.
// R8: faults are outputs off, backplane power, host comm, I/O comm, field power lost.
// R9: host must put the default value inside the selected range.
// R10: enabled and fault-free applies the command, ramped at the enabled rate if non-zero.
// R11: disable, fault or reconfiguration go to default, ramped at default rate if set.
// R12: backplane power loss ignores default ramp; default steps, hold keeps value.
// R13: first store after backplane power return steps to default; later stores ramp.
// R14: converter power kept and same config restored leaves the output unchanged.
// R15: hot removal, reset service request or cleared config hold the last value; the code holds on hot removal only while outputs are enabled.
// R16: field power loss drives zero volts and zero milliamps on the output.
// R17: scaling is bypassed when both engineering points equal both converter points.
// R18: host keeps low point below high point; scale defaults equal the range limits.
// R19: engineering maps to converter on the line through both point pairs, extrapolated.
// R20: default scaling spans the whole range, one engineering unit per range unit.
// R21: alarm thresholds compare against the engineering value, never converter units.
// R22: ramps step by the rate each update, stop exactly at target; zero rate steps.
`ifndef AOC_DEFINES_SVH
`define AOC_DEFINES_SVH

// register byte offsets
`define AOC_REG_CTRL      8'h00
`define AOC_REG_CMD       8'h04
`define AOC_REG_DFLT      8'h08
`define AOC_REG_ENG_HI    8'h0C
`define AOC_REG_ENG_LO    8'h10
`define AOC_REG_CNV_HI    8'h14
`define AOC_REG_CNV_LO    8'h18
`define AOC_REG_RATE_EN   8'h1C
`define AOC_REG_RATE_DEF  8'h20
`define AOC_REG_ALM_HI    8'h24
`define AOC_REG_ALM_LO    8'h28
`define AOC_REG_ACTION    8'h2C
`define AOC_REG_STATUS    8'h30
`define AOC_REG_ENG_NOW   8'h34
`define AOC_REG_DAC_NOW   8'h38

// control fields
`define AOC_CTRL_RTYPE_LSB 0
`define AOC_CTRL_RANGE_LSB 2
`define AOC_CTRL_FLOAT_BIT 4
`define AOC_CTRL_HOLD_BIT  5
`define AOC_RTYPE_DIS_V    2'h0
`define AOC_RTYPE_DIS_I    2'h1
`define AOC_RTYPE_ACTIVE   2'h2
`define AOC_RANGE_PM10V    2'h0
`define AOC_RANGE_0_10V    2'h1
`define AOC_RANGE_4_20MA   2'h2
`define AOC_RANGE_0_20MA   2'h3
`define AOC_RST_RTYPE      `AOC_RTYPE_DIS_I
`define AOC_RST_RANGE      `AOC_RANGE_PM10V
`define AOC_RST_FLOAT      1'h1
`define AOC_RST_HOLD       1'h0

// action bits (write one to fire)
`define AOC_ACT_STORE 0
`define AOC_ACT_CLEAR 1
`define AOC_ACT_SVC   2

// range limits, signed Q16.16
`define AOC_LIM_M10 32'hFFF60000
`define AOC_LIM_P10 32'h000A0000
`define AOC_LIM_0   32'h00000000
`define AOC_LIM_P4  32'h00040000
`define AOC_LIM_P20 32'h00140000

// timing
`define AOC_CLK_MHZ    125
`define AOC_UPDATE_US  1000
`define AOC_TICK_W     17
`define AOC_DIV_STEPS  7'h40

`define AOC_RESP_OKAY   2'h0
`define AOC_RESP_SLVERR 2'h2

`endif

//--- core/aoc_pkg.sv
package aoc_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_SCALE, ST_DIV} aoc_fsm_t;

    typedef struct packed {
        logic [6:0]  s1;
        logic [6:0]  s2;
        logic        bp_prev;
        logic [1:0]  rtype;
        logic [1:0]  range;
        logic        fmt_float;
        logic        hold;
        logic [31:0] cmd, dflt, eng_hi, eng_lo, cnv_hi, cnv_lo;
        logic [31:0] rate_en, rate_def, alm_hi, alm_lo;
        logic [31:0] cur, dac;
        logic        zero_i, zero_v, alm_hi_f, alm_lo_f;
        logic        freeze, first_store, reconf, jump;
        logic [31:0] snap;
        logic [16:0] tick_cnt;
        aoc_fsm_t    fsm;
        logic [63:0] dvd;
        logic [32:0] rem;
        logic [31:0] dsr, quo;
        logic [6:0]  cnt;
        logic        neg;
        logic        awready, wready, bvalid;
        logic [1:0]  bresp;
        logic        arready, rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } aoc_state_t;

endpackage : aoc_pkg

//--- core/aoc_channel.sv
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "aoc_defines.svh"

module aoc_channel #(
    parameter int unsigned UPDATE_CYCLES = `AOC_UPDATE_US * `AOC_CLK_MHZ
) (
    // clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        SRST_IN,
    // axi4-lite write
    input  wire logic [7:0]  AXI_AWADDR_IN,
    input  wire logic        AXI_AWVALID_IN,
    output logic             AXI_AWREADY_OUT,
    input  wire logic [31:0] AXI_WDATA_IN,
    input  wire logic [3:0]  AXI_WSTRB_IN,
    input  wire logic        AXI_WVALID_IN,
    output logic             AXI_WREADY_OUT,
    output logic [1:0]       AXI_BRESP_OUT,
    output logic             AXI_BVALID_OUT,
    input  wire logic        AXI_BREADY_IN,
    // axi4-lite read
    input  wire logic [7:0]  AXI_ARADDR_IN,
    input  wire logic        AXI_ARVALID_IN,
    output logic             AXI_ARREADY_OUT,
    output logic [31:0]      AXI_RDATA_OUT,
    output logic [1:0]       AXI_RRESP_OUT,
    output logic             AXI_RVALID_OUT,
    input  wire logic        AXI_RREADY_IN,
    // system condition pins, asynchronous
    input  wire logic        OUTPUTS_ENABLED_IN,
    input  wire logic        BP_POWER_OK_IN,
    input  wire logic        HOST_COMM_OK_IN,
    input  wire logic        IO_COMM_OK_IN,
    input  wire logic        FIELD_POWER_OK_IN,
    input  wire logic        HOT_REMOVAL_IN,
    input  wire logic        CONV_POWER_KEPT_IN,
    // converter side
    output logic [31:0]      DAC_VALUE_OUT,
    output logic             ZERO_CURRENT_OUT,
    output logic             ZERO_VOLTAGE_OUT
);

    aoc_pkg::aoc_state_t st;
    aoc_pkg::aoc_state_t next_st;

    // float32 to signed Q16.16, saturating; denormals and tiny values read as zero
    function automatic logic [31:0] f2q(input logic [31:0] f);
        logic [7:0]  e;
        logic [54:0] m;
        logic [31:0] mag;
        e = f[30:23];
        m = {31'h0, 1'b1, f[22:0]};
        if (e < 8'h4F)
            mag = 32'h0;
        else if (e >= 8'h8E)
            mag = 32'h7FFFFFFF;
        else if (e >= 8'h86)
            mag = 32'(m << (e - 8'h86));
        else
            mag = 32'(m >> (8'h86 - e));
        return f[31] ? 32'(-mag) : mag;
    endfunction : f2q

    function automatic logic [31:0] ramp(input logic [31:0] c, input logic [31:0] t,
                                         input logic [31:0] r);
        logic signed [32:0] d;
        logic [32:0]        ad;
        d  = $signed({t[31], t}) - $signed({c[31], c});
        ad = d[32] ? 33'(-d) : 33'(d);
        if (r == 32'h0 || ad <= {1'b0, r})
            return t; // R22
        return d[32] ? 32'(c - r) : 32'(c + r); // R22
    endfunction : ramp

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction : wmerge

    function automatic logic [31:0] lim_hi(input logic [1:0] rg);
        return (rg == `AOC_RANGE_4_20MA || rg == `AOC_RANGE_0_20MA) ? `AOC_LIM_P20 : `AOC_LIM_P10;
    endfunction : lim_hi

    function automatic logic [31:0] lim_lo(input logic [1:0] rg);
        unique case (rg)
            `AOC_RANGE_PM10V:  return `AOC_LIM_M10;
            `AOC_RANGE_4_20MA: return `AOC_LIM_P4;
            default:           return `AOC_LIM_0;
        endcase
    endfunction : lim_lo

    // cheap fingerprint of the stored configuration, enough to spot a changed restore
    function automatic logic [31:0] cfg_sig(input aoc_pkg::aoc_state_t s);
        return {26'h0, s.hold, s.fmt_float, s.range, s.rtype} ^ s.dflt ^ s.eng_hi ^ s.eng_lo
               ^ s.cnv_hi ^ s.cnv_lo ^ s.rate_en ^ s.rate_def;
    endfunction : cfg_sig

    always_comb begin
        logic               oe, bp, host, io, fp, hot, kept, fault, fin, tick;
        logic               act_store, act_clear, act_svc, ge;
        logic [31:0]        wd, tgt, rate, res, q;
        logic [7:0]         wa;
        logic signed [32:0] da, db;
        logic signed [65:0] p;
        logic [32:0]        rem2;
        oe        = st.s2[0];
        bp        = st.s2[1];
        host      = st.s2[2];
        io        = st.s2[3];
        fp        = st.s2[4];
        hot       = st.s2[5];
        kept      = st.s2[6];
        fault     = !oe || !bp || !host || !io || !fp; // R8
        fin       = 1'b0;
        res       = 32'h0;
        tgt       = st.cur;
        rate      = 32'h0;
        q         = 32'h0;
        act_store = 1'b0;
        act_clear = 1'b0;
        act_svc   = 1'b0;
        wa        = AXI_AWADDR_IN;
        wd        = AXI_WDATA_IN;
        da        = 33'sh0;
        db        = 33'sh0;
        p         = 66'sh0;
        rem2      = 33'h0;
        ge        = 1'b0;
        next_st   = st;

        next_st.s1 = {CONV_POWER_KEPT_IN, HOT_REMOVAL_IN, FIELD_POWER_OK_IN, IO_COMM_OK_IN,
                      HOST_COMM_OK_IN, BP_POWER_OK_IN, OUTPUTS_ENABLED_IN};
        next_st.s2 = st.s1;

        // update-period divider
        tick = (st.tick_cnt == 17'(UPDATE_CYCLES - 1));
        next_st.tick_cnt = tick ? 17'h0 : 17'(st.tick_cnt + 17'h1);

        // write channel: address and data are taken together
        next_st.awready = 1'b0;
        next_st.wready  = 1'b0;
        if (st.bvalid && AXI_BREADY_IN)
            next_st.bvalid = 1'b0;
        if (!st.bvalid && !st.awready && AXI_AWVALID_IN && AXI_WVALID_IN) begin
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end
        if (st.awready) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = `AOC_RESP_OKAY;
            unique case (wa)
                `AOC_REG_CTRL: begin
                    if (AXI_WSTRB_IN[0]) begin
                        next_st.rtype     = wd[`AOC_CTRL_RTYPE_LSB +: 2]; // R1
                        next_st.range     = wd[`AOC_CTRL_RANGE_LSB +: 2]; // R2
                        next_st.fmt_float = wd[`AOC_CTRL_FLOAT_BIT]; // R4
                        next_st.hold      = wd[`AOC_CTRL_HOLD_BIT];
                        // new range reloads the scale points to its own limits
                        if (wd[`AOC_CTRL_RANGE_LSB +: 2] != st.range) begin
                            next_st.eng_hi = lim_hi(wd[`AOC_CTRL_RANGE_LSB +: 2]); // R20
                            next_st.cnv_hi = lim_hi(wd[`AOC_CTRL_RANGE_LSB +: 2]); // R18
                            next_st.eng_lo = lim_lo(wd[`AOC_CTRL_RANGE_LSB +: 2]); // R20
                            next_st.cnv_lo = lim_lo(wd[`AOC_CTRL_RANGE_LSB +: 2]); // R18
                        end
                    end
                end
                `AOC_REG_CMD: begin
                    next_st.cmd    = wmerge(st.cmd, wd, AXI_WSTRB_IN);
                    next_st.reconf = 1'b0;
                end
                `AOC_REG_DFLT:     next_st.dflt     = wmerge(st.dflt, wd, AXI_WSTRB_IN);
                `AOC_REG_ENG_HI:   next_st.eng_hi   = wmerge(st.eng_hi, wd, AXI_WSTRB_IN);
                `AOC_REG_ENG_LO:   next_st.eng_lo   = wmerge(st.eng_lo, wd, AXI_WSTRB_IN);
                `AOC_REG_CNV_HI:   next_st.cnv_hi   = wmerge(st.cnv_hi, wd, AXI_WSTRB_IN);
                `AOC_REG_CNV_LO:   next_st.cnv_lo   = wmerge(st.cnv_lo, wd, AXI_WSTRB_IN);
                `AOC_REG_RATE_EN:  next_st.rate_en  = wmerge(st.rate_en, wd, AXI_WSTRB_IN);
                `AOC_REG_RATE_DEF: next_st.rate_def = wmerge(st.rate_def, wd, AXI_WSTRB_IN);
                `AOC_REG_ALM_HI:   next_st.alm_hi   = wmerge(st.alm_hi, wd, AXI_WSTRB_IN);
                `AOC_REG_ALM_LO:   next_st.alm_lo   = wmerge(st.alm_lo, wd, AXI_WSTRB_IN);
                `AOC_REG_ACTION: begin
                    act_store = AXI_WSTRB_IN[0] && wd[`AOC_ACT_STORE];
                    act_clear = AXI_WSTRB_IN[0] && wd[`AOC_ACT_CLEAR];
                    act_svc   = AXI_WSTRB_IN[0] && wd[`AOC_ACT_SVC];
                end
                `AOC_REG_STATUS, `AOC_REG_ENG_NOW, `AOC_REG_DAC_NOW: ;
                default: next_st.bresp = `AOC_RESP_SLVERR;
            endcase
        end

        // read channel
        next_st.arready = 1'b0;
        if (st.rvalid && AXI_RREADY_IN)
            next_st.rvalid = 1'b0;
        if (!st.rvalid && !st.arready && AXI_ARVALID_IN)
            next_st.arready = 1'b1;
        if (st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `AOC_RESP_OKAY;
            unique case (AXI_ARADDR_IN)
                `AOC_REG_CTRL:     next_st.rdata = {26'h0, st.hold, st.fmt_float, st.range,
                                                    st.rtype};
                `AOC_REG_CMD:      next_st.rdata = st.cmd;
                `AOC_REG_DFLT:     next_st.rdata = st.dflt;
                `AOC_REG_ENG_HI:   next_st.rdata = st.eng_hi;
                `AOC_REG_ENG_LO:   next_st.rdata = st.eng_lo;
                `AOC_REG_CNV_HI:   next_st.rdata = st.cnv_hi;
                `AOC_REG_CNV_LO:   next_st.rdata = st.cnv_lo;
                `AOC_REG_RATE_EN:  next_st.rdata = st.rate_en;
                `AOC_REG_RATE_DEF: next_st.rdata = st.rate_def;
                `AOC_REG_ALM_HI:   next_st.rdata = st.alm_hi;
                `AOC_REG_ALM_LO:   next_st.rdata = st.alm_lo;
                `AOC_REG_ACTION:   next_st.rdata = 32'h0;
                `AOC_REG_STATUS:   next_st.rdata = {20'h0, fault, st.jump, st.reconf,
                                                    st.first_store, st.freeze, st.alm_lo_f,
                                                    st.alm_hi_f, st.zero_v, st.zero_i, kept,
                                                    fp, bp};
                `AOC_REG_ENG_NOW:  next_st.rdata = st.cur;
                `AOC_REG_DAC_NOW:  next_st.rdata = st.dac;
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = `AOC_RESP_SLVERR;
                end
            endcase
        end

        // power and configuration events; sets are applied after clears so they win
        next_st.bp_prev = bp;
        if (act_store) begin
            next_st.freeze = 1'b0;
            next_st.snap   = cfg_sig(st);
            if (st.first_store) begin
                next_st.first_store = 1'b0;
                // unchanged restore with converter power kept leaves the output alone
                if (!(kept && cfg_sig(st) == st.snap))
                    next_st.jump = 1'b1; // R13 R14
            end else begin
                next_st.reconf = 1'b1; // R11 R13
            end
        end
        if (bp && !st.bp_prev)
            next_st.first_store = 1'b1; // R13
        if (act_clear || act_svc || (hot && oe))
            next_st.freeze = 1'b1; // R15

        // output engine
        unique case (st.fsm)
            aoc_pkg::ST_IDLE: begin
                if (tick) begin
                    if (!fp) begin
                        next_st.dac    = 32'h0; // R16
                        next_st.zero_i = 1'b1; // R16
                        next_st.zero_v = 1'b1; // R16
                    end else begin
                        if (st.freeze) begin
                            tgt = st.cur; // R15
                        end else if (st.jump || !bp) begin
                            // no ramp here: step to default or keep the last value
                            tgt          = st.hold ? st.cur : st.dflt; // R12 R13
                            next_st.jump = 1'b0;
                        end else if (fault || st.reconf) begin
                            tgt  = st.hold ? st.cur : st.dflt; // R7 R11
                            rate = st.rate_def; // R11
                        end else begin
                            tgt  = st.fmt_float ? f2q(st.cmd) : {st.cmd[15:0], 16'h0}; // R4 R10
                            rate = st.rate_en; // R10
                        end
                        next_st.cur = ramp(st.cur, tgt, rate); // R22
                        next_st.fsm = aoc_pkg::ST_SCALE;
                    end
                end
            end
            aoc_pkg::ST_SCALE: begin
                next_st.alm_hi_f = $signed(st.cur) >= $signed(st.alm_hi); // R21
                next_st.alm_lo_f = $signed(st.cur) <= $signed(st.alm_lo); // R21
                da = $signed({st.cur[31], st.cur}) - $signed({st.eng_lo[31], st.eng_lo});
                db = $signed({st.cnv_hi[31], st.cnv_hi}) - $signed({st.cnv_lo[31], st.cnv_lo});
                p  = da * db;
                next_st.dvd = p[65] ? 64'(-p) : 64'(p);
                da = $signed({st.eng_hi[31], st.eng_hi}) - $signed({st.eng_lo[31], st.eng_lo});
                next_st.dsr = da[32] ? 32'(-da) : 32'(da);
                next_st.neg = p[65] ^ da[32];
                next_st.rem = 33'h0;
                next_st.quo = 32'h0;
                next_st.cnt = `AOC_DIV_STEPS;
                // equal points skip the divider; a zero span would divide by zero
                if ((st.eng_hi == st.cnv_hi && st.eng_lo == st.cnv_lo) || da == 33'sh0) begin
                    fin = 1'b1; // R17
                    res = st.cur; // R17
                end else begin
                    next_st.fsm = aoc_pkg::ST_DIV;
                end
            end
            aoc_pkg::ST_DIV: begin
                rem2        = {st.rem[31:0], st.dvd[63]};
                ge          = rem2 >= {1'b0, st.dsr};
                next_st.rem = ge ? 33'(rem2 - {1'b0, st.dsr}) : rem2;
                q           = {st.quo[30:0], ge};
                next_st.quo = q;
                next_st.dvd = {st.dvd[62:0], 1'b0};
                next_st.cnt = 7'(st.cnt - 7'h1);
                if (st.cnt == 7'h1) begin
                    fin = 1'b1;
                    res = 32'(st.cnv_lo + (st.neg ? 32'(-q) : q)); // R19
                end
            end
        endcase

        if (fin) begin
            next_st.fsm    = aoc_pkg::ST_IDLE;
            next_st.dac    = (st.rtype == `AOC_RTYPE_ACTIVE || st.rtype == 2'h3) ? res : 32'h0;
            next_st.zero_i = (st.rtype == `AOC_RTYPE_DIS_I); // R5
            next_st.zero_v = (st.rtype == `AOC_RTYPE_DIS_V); // R6
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN) begin
            st             <= '0;
            st.rtype       <= `AOC_RST_RTYPE; // R1
            st.range       <= `AOC_RST_RANGE; // R2
            st.fmt_float   <= `AOC_RST_FLOAT; // R4
            st.hold        <= `AOC_RST_HOLD;
            st.eng_hi      <= `AOC_LIM_P10; // R20
            st.eng_lo      <= `AOC_LIM_M10; // R20
            st.cnv_hi      <= `AOC_LIM_P10;
            st.cnv_lo      <= `AOC_LIM_M10;
            st.zero_i      <= 1'b1; // R5
            st.first_store <= 1'b1;
            st.fsm         <= aoc_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign AXI_AWREADY_OUT  = st.awready;
    assign AXI_WREADY_OUT   = st.wready;
    assign AXI_BRESP_OUT    = st.bresp;
    assign AXI_BVALID_OUT   = st.bvalid;
    assign AXI_ARREADY_OUT  = st.arready;
    assign AXI_RDATA_OUT    = st.rdata;
    assign AXI_RRESP_OUT    = st.rresp;
    assign AXI_RVALID_OUT   = st.rvalid;
    assign DAC_VALUE_OUT    = st.dac;
    assign ZERO_CURRENT_OUT = st.zero_i;
    assign ZERO_VOLTAGE_OUT = st.zero_v;

endmodule : aoc_channel

//--- sim/aoc_host_model.sv
`timescale 1ns/1ns
module aoc_host_model (
    input  wire logic       clk_in,
    input  wire logic [6:0] cond_in,
    output logic      [6:0] pins_out = 7'h00
);
    // status moves only after an edge, as the backplane reports it
    always @(posedge clk_in) begin
        pins_out <= cond_in;
    end
endmodule : aoc_host_model

//--- sim/aoc_channel_assertions.sv
`timescale 1ns/1ns
module aoc_channel_assertions #(
    parameter int unsigned UPDATE_CYCLES = 200
) (
    input logic        CLK_SYS_IN,
    input logic        SRST_IN,
    input logic        FIELD_POWER_OK_IN,
    input logic        AXI_RREADY_IN,
    input logic        AXI_AWREADY_OUT,
    input logic        AXI_WREADY_OUT,
    input logic        AXI_BVALID_OUT,
    input logic        AXI_ARREADY_OUT,
    input logic        AXI_RVALID_OUT,
    input logic [31:0] DAC_VALUE_OUT,
    input logic        ZERO_CURRENT_OUT,
    input logic        ZERO_VOLTAGE_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SRST_IN);
    // margin covers pin sync, a whole update period and the output stage
    logic [31:0] low_cnt;
    always_ff @(posedge CLK_SYS_IN) begin
        if (SRST_IN || FIELD_POWER_OK_IN) low_cnt <= 32'h0;
        else if (low_cnt <= UPDATE_CYCLES + 8) low_cnt <= low_cnt + 32'h1;
    end
    property p_rst; $fell(SRST_IN) |-> ZERO_CURRENT_OUT && DAC_VALUE_OUT == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_zi; ZERO_CURRENT_OUT |-> DAC_VALUE_OUT == 32'h0; endproperty
    a_zi: assert property (p_zi) else $error("zero current with output");
    property p_zv; ZERO_VOLTAGE_OUT |-> DAC_VALUE_OUT == 32'h0; endproperty
    a_zv: assert property (p_zv) else $error("zero voltage with output");
    property p_field;
        low_cnt > UPDATE_CYCLES + 8 |-> ZERO_CURRENT_OUT && ZERO_VOLTAGE_OUT;
    endproperty
    a_field: assert property (p_field) else $error("field loss not zeroed");
    property p_wr; AXI_AWREADY_OUT |-> AXI_WREADY_OUT ##1 AXI_BVALID_OUT; endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_bv; AXI_BVALID_OUT |=> !AXI_AWREADY_OUT; endproperty
    a_bv: assert property (p_bv) else $error("second write too early");
    property p_rd; AXI_ARREADY_OUT |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_rdrop; AXI_RVALID_OUT && AXI_RREADY_IN |=> !AXI_RVALID_OUT; endproperty
    a_rdrop: assert property (p_rdrop) else $error("read data not released");
endmodule : aoc_channel_assertions
bind aoc_channel aoc_channel_assertions #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_aoc_chk (.*);

//--- sim/tb_aoc_channel.sv
`timescale 1ns/1ns
`include "aoc_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, (a), (e)); end end
module tb_aoc_channel;
    localparam int UC = 200;
    logic        clk = 1'b0, srst = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, v;
    logic [6:0]  cond = 7'h1F;
    logic [15:0] lfsr = 16'h80E0;
    logic [33:0] expq[$], e_now;
    int          num_errors = 0, check_count = 0;
    wire  [6:0]  pins;
    wire         awready, wready, bvalid, arready, rvalid, zi, zv;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, dac;
    aoc_host_model u_aoc_host_model (.clk_in(clk), .cond_in(cond), .pins_out(pins));
    aoc_channel #(.UPDATE_CYCLES(UC)) u_aoc_channel (
        .CLK_SYS_IN(clk), .SRST_IN(srst), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
        .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF),
        .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
        .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
        .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
        .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
        .OUTPUTS_ENABLED_IN(pins[0]), .BP_POWER_OK_IN(pins[1]), .HOST_COMM_OK_IN(pins[2]),
        .IO_COMM_OK_IN(pins[3]), .FIELD_POWER_OK_IN(pins[4]), .HOT_REMOVAL_IN(pins[5]),
        .CONV_POWER_KEPT_IN(pins[6]), .DAC_VALUE_OUT(dac), .ZERO_CURRENT_OUT(zi),
        .ZERO_VOLTAGE_OUT(zv));
    initial forever #4 clk = ~clk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        expq.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        expq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask : rd
    // three update periods, room for the divider at any tick phase
    task automatic dac_is(input logic [31:0] e);
        repeat (3 * UC) @(posedge clk);
        `CHK(dac, e)
        rd(`AOC_REG_DAC_NOW, {2'h0, e});
    endtask : dac_is
    task automatic flags_are(input logic [1:0] f);
        repeat (3 * UC) @(posedge clk);
        `CHK({zi, zv, dac}, {f, 32'h0})
    endtask : flags_are
    task automatic wait_change(input logic [31:0] old);
        for (int i = 0; i < 3 * UC && dac === old; i++) @(posedge clk);
    endtask : wait_change
    always @(posedge clk) begin
        if ((rvalid && rready) || (bvalid && bready)) begin
            e_now = expq.pop_front();
            if (rvalid) `CHK({rresp, rdata}, e_now)
            else `CHK({bresp, 32'h0}, e_now)
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({zi, zv, dac}, {2'h2, 32'h0})
        rd(`AOC_REG_CTRL, 34'h000000011);
        rd(8'h3C, 34'h200000000);
        wr(`AOC_REG_DFLT, 32'h00020000, 2'h0);
        wr(`AOC_REG_CTRL, 32'h12, 2'h0);
        wr(`AOC_REG_CMD, 32'hC0200000, 2'h0);
        dac_is(32'hFFFD8000);
        wr(`AOC_REG_CTRL, 32'h2, 2'h0);
        repeat (3) begin
            lfsr = lfsr_next(lfsr);
            v = {16'(lfsr % 16'h0015) - 16'h000A, 16'h0};
            wr(`AOC_REG_CMD, {16'h0, v[31:16]}, 2'h0);
            dac_is(v);
        end
        wr(`AOC_REG_CMD, 32'h0, 2'h0);
        dac_is(32'h0);
        wr(`AOC_REG_RATE_EN, 32'h00030000, 2'h0);
        wr(`AOC_REG_CMD, 32'h7, 2'h0);
        wait_change(32'h0);
        `CHK(dac, 32'h00030000)
        dac_is(32'h00070000);
        wr(`AOC_REG_RATE_DEF, 32'h00010000, 2'h0);
        for (int b = 0; b < 4; b++) begin
            cond <= 7'h1F ^ (7'h01 << b);
            wait_change(32'h00070000);
            `CHK(dac, (b == 1) ? 32'h00020000 : 32'h00060000)
            cond <= 7'h1F;
            dac_is(32'h00070000);
        end
        wr(`AOC_REG_CTRL, 32'h22, 2'h0);
        cond <= 7'h1B;
        dac_is(32'h00070000);
        cond <= 7'h1F;
        wr(`AOC_REG_CTRL, 32'h2, 2'h0);
        wr(`AOC_REG_ACTION, 32'h4, 2'h0);
        cond <= 7'h1B;
        dac_is(32'h00070000);
        wr(`AOC_REG_ACTION, 32'h1, 2'h0);
        wait_change(32'h00070000);
        `CHK(dac, 32'h00020000)
        dac_is(32'h00020000);
        cond <= 7'h1F;
        wr(`AOC_REG_RATE_EN, 32'h0, 2'h0);
        wr(`AOC_REG_ENG_HI, 32'h00140000, 2'h0);
        wr(`AOC_REG_ENG_LO, 32'h0, 2'h0);
        wr(`AOC_REG_CMD, 32'h5, 2'h0);
        dac_is(32'hFFFB0000);
        wr(`AOC_REG_CMD, 32'h1E, 2'h0);
        dac_is(32'h00140000);
        wr(`AOC_REG_CTRL, 32'h0, 2'h0);
        flags_are(2'h1);
        wr(`AOC_REG_CTRL, 32'h1, 2'h0);
        flags_are(2'h2);
        wr(`AOC_REG_CTRL, 32'hA, 2'h0);
        cond <= 7'h0F;
        flags_are(2'h3);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule : tb_aoc_channel
